// >>> rtl/gtp_pkg.sv
// package: register map, field layout and reset values of the gpio block
package gtp_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] P0_DIR_ADDR = 8'hb8;
  localparam logic [7:0] P1_DIR_ADDR = 8'hc1;
  localparam logic [7:0] P5_DIR_ADDR = 8'hc5;
  localparam logic [7:0] P0_DATA_ADDR = 8'hd0;
  localparam logic [7:0] P1_DATA_ADDR = 8'hd1;
  localparam logic [7:0] P5_DATA_ADDR = 8'hd5;
  localparam logic [7:0] P1_WAKE_ADDR = 8'hc0;
  localparam logic [7:0] P0_PULLUP_ADDR = 8'he0;
  localparam logic [7:0] P1_PULLUP_ADDR = 8'he1;
  localparam logic [7:0] P5_PULLUP_ADDR = 8'he5;
  localparam logic [7:0] OD_SEL_ADDR = 8'he9;
  localparam logic [7:0] IRQ_STATUS_ADDR = 8'hc8;
  localparam logic [7:0] IRQ_MASK_ADDR = 8'hc9;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int P0_WIDTH = 6;
  localparam int P0_CTRL_WIDTH = 5;
  localparam int P1_WIDTH = 8;
  localparam int P5_WIDTH = 3;
  localparam int OD_WIDTH = 4;
  localparam int IRQ_WIDTH = 1;
  localparam int P0_INPUT_ONLY_BIT = 5;
  localparam int OD_P1_BIT0 = 0;
  localparam int OD_P1_BIT1 = 1;
  localparam int OD_P5_BIT0 = 2;
  localparam int OD_P5_BIT2 = 3;
  localparam int IRQ_WAKE_BIT = 0;
  localparam logic [7:0] FULL_MASK = 8'hff;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [7:0] DIR_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [7:0] PULLUP_RESET = 8'h00;
  localparam logic [7:0] WAKE_RESET = 8'h00;
  localparam logic [3:0] OD_RESET = 4'h0;
  localparam logic [7:0] RDATA_RESET = 8'h00;

endpackage : gtp_pkg

// >>> rtl/gtp_gpio.sv
// gpio block with three ports, pull-ups, open-drain pins and port wake-up
`timescale 1ns/10ps
module gtp_gpio
  import gtp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] wr_mask,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [P0_WIDTH-1:0] p0_in,
  input wire logic [P1_WIDTH-1:0] p1_in,
  input wire logic [P5_WIDTH-1:0] p5_in,
  input wire logic ext_reset_opt,
  input wire logic sleep,
  output logic [P0_CTRL_WIDTH-1:0] p0_out,
  output logic [P0_CTRL_WIDTH-1:0] p0_oe,
  output logic [P1_WIDTH-1:0] p1_out,
  output logic [P1_WIDTH-1:0] p1_oe,
  output logic [P5_WIDTH-1:0] p5_out,
  output logic [P5_WIDTH-1:0] p5_oe,
  output logic [P0_CTRL_WIDTH-1:0] p0_pullup,
  output logic [P1_WIDTH-1:0] p1_pullup,
  output logic [P5_WIDTH-1:0] p5_pullup,
  output logic wake_req,
  output logic irq
);

  // ****************************************************************
  // helpers
  // ****************************************************************
  function automatic logic [7:0] merge_bits(input logic [7:0] old,
                                           input logic [7:0] val,
                                           input logic [7:0] msk);
    merge_bits = (old & ~msk) | (val & msk);
  endfunction : merge_bits

  function automatic logic wr_hit(input logic w, input logic [7:0] a,
                                  input logic [7:0] target);
    wr_hit = w && (a == target);
  endfunction : wr_hit

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  logic [P0_CTRL_WIDTH-1:0] p0_dir;
  logic [P1_WIDTH-1:0] p1_dir;
  logic [P5_WIDTH-1:0] p5_dir;
  logic [P0_CTRL_WIDTH-1:0] p0_lat;
  logic [P1_WIDTH-1:0] p1_lat;
  logic [P5_WIDTH-1:0] p5_lat;
  logic [P1_WIDTH-1:0] p1_wake_en;
  logic [OD_WIDTH-1:0] od_sel;
  logic [IRQ_WIDTH-1:0] irq_status;
  logic [IRQ_WIDTH-1:0] irq_mask;

  // per-bit write mask lets software do single-bit set and clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p0_dir <= DIR_RESET[P0_CTRL_WIDTH-1:0];
      p1_dir <= DIR_RESET[P1_WIDTH-1:0];
      p5_dir <= DIR_RESET[P5_WIDTH-1:0];
    end else begin
      if (wr_hit(wr, addr, P0_DIR_ADDR)) begin
        p0_dir <= P0_CTRL_WIDTH'(merge_bits({3'h0, p0_dir}, wdata,
                                            wr_mask));
      end
      if (wr_hit(wr, addr, P1_DIR_ADDR)) begin
        p1_dir <= merge_bits(p1_dir, wdata, wr_mask);
      end
      if (wr_hit(wr, addr, P5_DIR_ADDR)) begin
        p5_dir <= P5_WIDTH'(merge_bits({5'h0, p5_dir}, wdata,
                                       wr_mask));
      end
    end
  end

  // latches take bit writes too; no read-modify-write of pin levels
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p0_lat <= DATA_RESET[P0_CTRL_WIDTH-1:0];
      p1_lat <= DATA_RESET[P1_WIDTH-1:0];
      p5_lat <= DATA_RESET[P5_WIDTH-1:0];
    end else begin
      if (wr_hit(wr, addr, P0_DATA_ADDR)) begin
        p0_lat <= P0_CTRL_WIDTH'(merge_bits({3'h0, p0_lat}, wdata,
                                            wr_mask));
      end
      if (wr_hit(wr, addr, P1_DATA_ADDR)) begin
        p1_lat <= merge_bits(p1_lat, wdata, wr_mask);
      end
      if (wr_hit(wr, addr, P5_DATA_ADDR)) begin
        p5_lat <= P5_WIDTH'(merge_bits({5'h0, p5_lat}, wdata,
                                       wr_mask));
      end
    end
  end

  // pull-up enables drive the pads straight from their flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p0_pullup <= PULLUP_RESET[P0_CTRL_WIDTH-1:0];
      p1_pullup <= PULLUP_RESET[P1_WIDTH-1:0];
      p5_pullup <= PULLUP_RESET[P5_WIDTH-1:0];
    end else begin
      if (wr_hit(wr, addr, P0_PULLUP_ADDR)) begin
        p0_pullup <= P0_CTRL_WIDTH'(merge_bits({3'h0, p0_pullup}, wdata,
                                               wr_mask));
      end
      if (wr_hit(wr, addr, P1_PULLUP_ADDR)) begin
        p1_pullup <= merge_bits(p1_pullup, wdata, wr_mask);
      end
      if (wr_hit(wr, addr, P5_PULLUP_ADDR)) begin
        p5_pullup <= P5_WIDTH'(merge_bits({5'h0, p5_pullup}, wdata,
                                          wr_mask));
      end
    end
  end

  // a partial-mask write is dropped: bit ops cannot reach this register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      od_sel <= OD_RESET;
    end else if (wr_hit(wr, addr, OD_SEL_ADDR) && wr_mask == FULL_MASK) begin
      od_sel <= wdata[OD_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p1_wake_en <= WAKE_RESET;
    end else begin
      if (wr_hit(wr, addr, P1_WAKE_ADDR)) begin
        p1_wake_en <= merge_bits(p1_wake_en, wdata, wr_mask);
      end
    end
  end

  // ****************************************************************
  // pad drive
  // ****************************************************************
  logic [P1_WIDTH-1:0] p1_od;
  logic [P5_WIDTH-1:0] p5_od;
  logic [P1_WIDTH-1:0] next_p1_out;
  logic [P1_WIDTH-1:0] next_p1_oe;
  logic [P5_WIDTH-1:0] next_p5_out;
  logic [P5_WIDTH-1:0] next_p5_oe;

  always_comb begin
    p1_od = '0;
    p1_od[0] = od_sel[OD_P1_BIT0];
    p1_od[1] = od_sel[OD_P1_BIT1];
    p5_od = '0;
    p5_od[0] = od_sel[OD_P5_BIT0];
    p5_od[2] = od_sel[OD_P5_BIT2];
  end

  // open-drain only sinks; the pad relies on the output mode set by software
  always_comb begin
    next_p1_out = p1_lat & ~p1_od;
    next_p1_oe = p1_dir & ~(p1_od & p1_lat);
    next_p5_out = p5_lat & ~p5_od;
    next_p5_oe = p5_dir & ~(p5_od & p5_lat);
  end

  // one cycle of latency keeps every pad signal on a flop
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p0_out <= '0;
      p0_oe <= '0;
      p1_out <= '0;
      p1_oe <= '0;
      p5_out <= '0;
      p5_oe <= '0;
    end else begin
      p0_out <= p0_lat;
      p0_oe <= p0_dir;
      p1_out <= next_p1_out;
      p1_oe <= next_p1_oe;
      p5_out <= next_p5_out;
      p5_oe <= next_p5_oe;
    end
  end

  // ****************************************************************
  // wake-up and interrupt
  // ****************************************************************
  logic [P1_WIDTH-1:0] p1_prev;
  logic [P0_CTRL_WIDTH-1:0] p0_prev;
  logic pin_change;
  logic next_wake_req;
  logic wake_event;
  logic status_read;
  logic [IRQ_WIDTH-1:0] next_irq_status;
  logic [IRQ_WIDTH-1:0] next_irq_mask;

  // pin 5 of port 0 doubles as reset, so it never wakes the device
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      p1_prev <= '0;
      p0_prev <= '0;
    end else begin
      p1_prev <= p1_in;
      p0_prev <= p0_in[P0_CTRL_WIDTH-1:0];
    end
  end

  always_comb begin
    pin_change = |((p1_in ^ p1_prev) & p1_wake_en)
               | |((p0_in[P0_CTRL_WIDTH-1:0] ^ p0_prev) & ~p0_dir);
    next_wake_req = sleep && (wake_req || pin_change);
    wake_event = next_wake_req && !wake_req;
    status_read = rd && (addr == IRQ_STATUS_ADDR);
    next_irq_status = irq_status;
    // irq follows a mask write at the same edge as the register does
    next_irq_mask = irq_mask;
    if (wr_hit(wr, addr, IRQ_MASK_ADDR)) begin
      next_irq_mask = IRQ_WIDTH'(merge_bits({7'h0, irq_mask}, wdata,
                                            wr_mask));
    end
    if (status_read) begin
      next_irq_status = '0;
    end
    // a wake in the clearing cycle survives the read
    if (wake_event) begin
      next_irq_status[IRQ_WAKE_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wake_req <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      wake_req <= next_wake_req;
      irq_status <= next_irq_status;
      irq_mask <= next_irq_mask;
      irq <= |(next_irq_status & next_irq_mask);
    end
  end

  // ****************************************************************
  // read path
  // ****************************************************************
  logic [7:0] next_rdata;
  logic [P0_WIDTH-1:0] p0_level;

  always_comb begin
    p0_level = p0_in;
    if (ext_reset_opt) begin
      p0_level[P0_INPUT_ONLY_BIT] = 1'b1;
    end
    next_rdata = RDATA_RESET;
    if (rd) begin
      unique case (addr)
        P0_DIR_ADDR: next_rdata = {3'h0, p0_dir};
        P1_DIR_ADDR: next_rdata = p1_dir;
        P5_DIR_ADDR: next_rdata = {5'h0, p5_dir};
        P0_DATA_ADDR: next_rdata = {2'h0, p0_level};
        P1_DATA_ADDR: next_rdata = p1_in;
        P5_DATA_ADDR: next_rdata = {5'h0, p5_in};
        P1_WAKE_ADDR: next_rdata = p1_wake_en;
        IRQ_STATUS_ADDR: next_rdata = {7'h0, irq_status};
        IRQ_MASK_ADDR: next_rdata = {7'h0, irq_mask};
        // write-only and unmapped addresses read zero
        default: next_rdata = RDATA_RESET;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= RDATA_RESET;
    end else begin
      rdata <= next_rdata;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  chk_dir_bit_write: assert property (
    wr && addr == P1_DIR_ADDR |=>
      p1_dir == (($past(p1_dir) & ~$past(wr_mask))
                 | ($past(wdata) & $past(wr_mask))))
    else $error("direction bit write disturbed other bits");

  chk_dir_drives_oe: assert property (
    !od_sel[OD_P1_BIT1] && $stable(od_sel) |=>
      p1_oe[1] == $past(p1_dir[1]))
    else $error("push-pull enable does not follow direction");

  chk_p0_dir_fixed: assert property (
    rd && addr == P0_DIR_ADDR |=> rdata[7:5] == 3'h0)
    else $error("port 0 pin 5 direction not fixed");

  chk_pullup_wo: assert property (
    rd && (addr == P1_PULLUP_ADDR || addr == OD_SEL_ADDR) |=>
      rdata == 8'h00)
    else $error("write-only register returned data");

  chk_od_whole_write: assert property (
    wr && addr == OD_SEL_ADDR && wr_mask != FULL_MASK |=> $stable(od_sel))
    else $error("open-drain select took a partial write");

  chk_od_sink_low: assert property (
    od_sel[OD_P1_BIT0] && p1_dir[0] && !p1_lat[0] |=>
      p1_oe[0] && !p1_out[0])
    else $error("open-drain pin not driven low");

  chk_od_release: assert property (
    od_sel[OD_P5_BIT2] && p5_lat[2] |=> !p5_oe[2] ##0 !p5_out[2])
    else $error("open-drain pin not released");

  chk_push_pull_back: assert property (
    !od_sel[OD_P1_BIT0] |=> p1_out[0] == $past(p1_lat[0]))
    else $error("push-pull data missing after open-drain off");

  chk_ext_reset_one: assert property (
    rd && addr == P0_DATA_ADDR && ext_reset_opt |=> rdata[5])
    else $error("port 0 pin 5 not one with external reset");

  chk_p1_level_read: assert property (
    rd && addr == P1_DATA_ADDR |=> rdata == $past(p1_in))
    else $error("port 1 read does not return pin levels");

  chk_wake_request: assert property (
    sleep && |((p1_in ^ p1_prev) & p1_wake_en) |=> wake_req)
    else $error("wake request missing after pin change");

  chk_wake_flag: assert property (
    $rose(wake_req) |-> irq_status[IRQ_WAKE_BIT] ##1
      (irq_status[IRQ_WAKE_BIT] || $past(status_read)))
    else $error("wake flag not set on wake");

  chk_irq_level: assert property (
    irq == |(irq_status & irq_mask))
    else $error("interrupt output disagrees with status");

  cov_wake_irq: cover property (sleep ##1 wake_req ##1 irq);
  cov_od_low: cover property (od_sel[OD_P1_BIT0] && p1_oe[0] && !p1_out[0]);
  cov_bit_write: cover property (wr && addr == P1_DIR_ADDR
                                 && wr_mask == 8'h04);
  cov_ext_reset: cover property (rd && addr == P0_DATA_ADDR
                                 && ext_reset_opt);

endmodule : gtp_gpio

// >>> verification/gtp_pin_model.sv
// board model: external drivers and resistors around the gpio pads
`timescale 1ns/10ps
module gtp_pin_model
  import gtp_pkg::*;
(
  input wire logic clk,
  input wire logic [4:0] p0_out,
  input wire logic [4:0] p0_oe,
  input wire logic [4:0] p0_pullup,
  input wire logic [7:0] p1_out,
  input wire logic [7:0] p1_oe,
  input wire logic [7:0] p1_pullup,
  input wire logic [2:0] p5_out,
  input wire logic [2:0] p5_oe,
  input wire logic [2:0] p5_pullup,
  input wire logic [16:0] ext_en,
  input wire logic [16:0] ext_val,
  output logic [5:0] p0_in,
  output logic [7:0] p1_in,
  output logic [2:0] p5_in
);
  // ****************
  // pin resolution
  // ****************
  // open-drain pins carry a board resistor, so released they read high
  localparam logic [16:0] BOARD_PU = 17'h140c0;
  logic [16:0] oe, drv, pull, lvl;
  logic [16:0] last = '0;
  assign oe = {p5_oe, p1_oe, 1'b0, p0_oe};
  assign drv = {p5_out, p1_out, 1'b0, p0_out};
  // the input-only pin has no pull-up at all
  assign pull = {p5_pullup, p1_pullup, 1'b0, p0_pullup}
              | BOARD_PU;
  // a floating pin with no pull-up flips each cycle so no stale level passes for data; a pulled one reads high
  always_comb begin
    for (int i = 0; i < 17; i++) begin
      if (oe[i]) begin
        lvl[i] = drv[i];
      end else if (ext_en[i]) begin
        lvl[i] = ext_val[i];
      end else begin
        lvl[i] = pull[i] | ~last[i];
      end
    end
  end
  always @(posedge clk) begin
    last <= lvl;
  end
  assign {p5_in, p1_in, p0_in} = lvl;
endmodule : gtp_pin_model

// >>> verification/tb_gtp_gpio.sv
// self-checking bench for the three-port gpio block
`timescale 1ns/10ps
module tb_gtp_gpio
  import gtp_pkg::*;
;
  // ****************
  // signals
  // ****************
  logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0;
  logic ext_reset_opt = 1'b0, sleep = 1'b0, wake_req, irq;
  logic [7:0] addr = 8'h00, wdata = 8'h00, wr_mask = 8'h00, rdata;
  logic [5:0] p0_in;
  logic [7:0] p1_in;
  logic [2:0] p5_in;
  logic [4:0] p0_out, p0_oe, p0_pullup;
  logic [7:0] p1_out, p1_oe, p1_pullup;
  logic [2:0] p5_out, p5_oe, p5_pullup;
  logic [16:0] ext_en = 17'h1ffff, ext_val = 17'h00000;
  logic [7:0] sh [256] = '{default: 8'h00};
  int bad_count = 0, tests_run = 0, cyc = 0;
  wire logic [16:0] pad_oe = {p5_oe, p1_oe, 1'b0, p0_oe};
  wire logic [16:0] pad_out = {p5_out, p1_out, 1'b0, p0_out};
  wire logic [16:0] pad_pu = {p5_pullup, p1_pullup, 1'b0, p0_pullup};

  gtp_gpio uut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr_mask(wr_mask),
    .wr(wr), .rd(rd), .rdata(rdata), .p0_in(p0_in), .p1_in(p1_in),
    .p5_in(p5_in), .ext_reset_opt(ext_reset_opt), .sleep(sleep),
    .p0_out(p0_out), .p0_oe(p0_oe), .p1_out(p1_out), .p1_oe(p1_oe),
    .p5_out(p5_out), .p5_oe(p5_oe), .p0_pullup(p0_pullup),
    .p1_pullup(p1_pullup), .p5_pullup(p5_pullup), .wake_req(wake_req),
    .irq(irq)
  );
  gtp_pin_model board (
    .clk(clk), .p0_out(p0_out), .p0_oe(p0_oe), .p0_pullup(p0_pullup),
    .p1_out(p1_out), .p1_oe(p1_oe), .p1_pullup(p1_pullup),
    .p5_out(p5_out), .p5_oe(p5_oe), .p5_pullup(p5_pullup),
    .ext_en(ext_en), .ext_val(ext_val), .p0_in(p0_in), .p1_in(p1_in),
    .p5_in(p5_in)
  );

  // ****************
  // tasks and sequence
  // ****************
  function automatic logic [16:0] pk(input logic [7:0] a0, a1, a5);
    return {sh[a5][2:0], sh[a1], 1'b0, sh[a0][4:0]};
  endfunction : pk
  function automatic logic [16:0] odm();
    logic [7:0] o;
    o = sh[OD_SEL_ADDR];
    return {o[3], 1'b0, o[2], 6'h00, o[1:0], 6'h00};
  endfunction : odm
  function automatic logic [16:0] exp_out();
    return pk(P0_DATA_ADDR, P1_DATA_ADDR, P5_DATA_ADDR) & ~odm();
  endfunction : exp_out
  function automatic logic [16:0] exp_oe();
    return pk(P0_DIR_ADDR, P1_DIR_ADDR, P5_DIR_ADDR)
      & ~(odm() & pk(P0_DATA_ADDR, P1_DATA_ADDR, P5_DATA_ADDR));
  endfunction : exp_oe

  task automatic chk(input string nm, input logic [16:0] e, g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic complete_run();
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic wr_reg(input logic [7:0] a, d, m);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_mask <= m;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    // partial writes to the open-drain register are dropped
    if (a != OD_SEL_ADDR || m == 8'hff) begin
      sh[a] = (sh[a] & ~m) | (d & m);
    end
  endtask : wr_reg
  task automatic rd_chk(input string nm, input logic [7:0] a, e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, {9'h000, e}, {9'h000, rdata});
    @(posedge clk);
    #1 chk("rdata_idle", 17'h00000, {9'h000, rdata});
  endtask : rd_chk
  // only pulled pins are left floating, so every read is defined
  task automatic drive_pins(input logic [16:0] v, f);
    logic [16:0] pm;
    pm = pk(P0_PULLUP_ADDR, P1_PULLUP_ADDR, P5_PULLUP_ADDR) | 17'h140c0;
    ext_val <= v;
    ext_en <= ~exp_oe() & ~(f & pm);
  endtask : drive_pins
  // k: pad index that must wake, j: pad index that must not
  task automatic wake_once(input int k, j, input logic m);
    wr_reg(IRQ_MASK_ADDR, {7'h00, m}, 8'hff);
    @(posedge clk);
    sleep <= 1'b1;
    ext_val[j] <= ~ext_val[j];
    repeat (3) @(posedge clk);
    #1 chk("no_wake", 17'h00000, {15'h0000, wake_req, irq});
    ext_val[k] <= ~ext_val[k];
    repeat (2) @(posedge clk);
    #1 chk("wake", {16'h0001, m}, {15'h0000, wake_req, irq});
    ext_val[k] <= ~ext_val[k];
    sleep <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk("wake_off", {16'h0000, m}, {15'h0000, wake_req, irq});
    rd_chk("flag", IRQ_STATUS_ADDR, 8'h01);
    chk("irq_clr", 17'h00000, {16'h0000, irq});
    rd_chk("flag_clr", IRQ_STATUS_ADDR, 8'h00);
  endtask : wake_once

  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end

  initial begin
    logic [31:0] r, q, u;
    logic [16:0] oe, lv;
    logic [7:0] o;
    int w;
    r = $urandom(32'h2aa2);
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 chk("oe_rst", 17'h00000, pad_oe);
    chk("out_rst", 17'h00000, pad_out);
    chk("pu_rst", 17'h00000, pad_pu);
    rd_chk("dir_rst", P1_DIR_ADDR, 8'h00);
    rd_chk("wake_rst", P1_WAKE_ADDR, 8'h00);
    rd_chk("unmapped", 8'h77, 8'h00);
    for (int n = 0; n < 30; n++) begin
      r = $urandom;
      q = $urandom;
      u = $urandom;
      wr_reg(OD_SEL_ADDR, {4'h0, q[22:19]}, {q[23], 7'h7f});
      o = sh[OD_SEL_ADDR];
      // software keeps open-drain pins in output mode
      wr_reg(P1_DIR_ADDR, r[15:8] | {6'h00, o[1:0]}, 8'hff);
      wr_reg(P5_DIR_ADDR, {5'h00, r[18:16] | {o[3], 1'b0, o[2]}}, 8'hff);
      wr_reg(P0_DIR_ADDR, r[7:0], 8'hff);
      wr_reg(P0_DIR_ADDR, {8{r[27]}}, 8'h01 << r[26:24]);
      wr_reg(P0_DATA_ADDR, q[7:0], 8'hff);
      wr_reg(P1_DATA_ADDR, q[15:8], 8'hff);
      wr_reg(P1_DATA_ADDR, {8{q[27]}}, 8'h01 << q[26:24]);
      wr_reg(P5_DATA_ADDR, {5'h00, q[18:16]}, 8'hff);
      wr_reg(P0_PULLUP_ADDR, r[31:24], 8'hff);
      wr_reg(P1_PULLUP_ADDR, q[31:24], 8'hff);
      wr_reg(P5_PULLUP_ADDR, {5'h00, r[22:20]}, 8'hff);
      ext_reset_opt <= r[28];
      drive_pins(u[16:0], u[31:15]);
      repeat (3) @(posedge clk);
      #1 oe = exp_oe();
      chk("pad_oe", oe, pad_oe);
      chk("pad_out", exp_out(), pad_out);
      lv = pk(P0_PULLUP_ADDR, P1_PULLUP_ADDR, P5_PULLUP_ADDR);
      chk("pad_pu", lv, pad_pu);
      lv = (oe & exp_out()) | (ext_en & ext_val) | ~(oe | ext_en);
      lv[5] = lv[5] | ext_reset_opt;
      rd_chk("p0_data", P0_DATA_ADDR, {2'b00, lv[5:0]});
      rd_chk("p1_data", P1_DATA_ADDR, lv[13:6]);
      rd_chk("p5_data", P5_DATA_ADDR, {5'h00, lv[16:14]});
      rd_chk("p0_dir", P0_DIR_ADDR, sh[P0_DIR_ADDR] & 8'h1f);
      rd_chk("p1_dir", P1_DIR_ADDR, sh[P1_DIR_ADDR]);
      rd_chk("od_wo", OD_SEL_ADDR, 8'h00);
      rd_chk("pu_wo", P1_PULLUP_ADDR, 8'h00);
    end
    wr_reg(OD_SEL_ADDR, 8'h00, 8'hff);
    wr_reg(P1_DIR_ADDR, 8'h00, 8'hff);
    wr_reg(P1_WAKE_ADDR, 8'h01 << r[2:0], 8'hff);
    rd_chk("wake_en", P1_WAKE_ADDR, 8'h01 << r[2:0]);
    drive_pins(ext_val, 17'h00000);
    w = 6 + int'(r[2:0]);
    wake_once(w, 6 + (w - 5) % 8, 1'b1);
    wake_once(w, 6 + (w - 5) % 8, 1'b0);
    // port 0 inputs wake too, with no enable register of their own
    wr_reg(P0_DIR_ADDR, 8'h00, 8'hff);
    drive_pins(ext_val, 17'h00000);
    wake_once(int'(r[2:0]) % 5, 6 + (w - 5) % 8, 1'b1);
    complete_run();
  end
endmodule : tb_gtp_gpio
